// >>> src/ssm_modulator.sv
// Spread-spectrum modulator: configuration register, enable sequencing
// and the frequency offset fed to the first fractional divider.
// Assumes register access and the nonvolatile load come from logic on
// the same clock, and that the divider adds div_offset to its ratio.
`timescale 1ns/1ps
`default_nettype none
module ssm_modulator (
  input wire logic clock,
  input wire logic srst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ssm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic nvm_load,
  input wire logic [31:0] nvm_data,
  input wire logic phase_align,
  input wire logic second_en,
  output logic [31:0] reg_rdata,
  output logic signed [ssm_pkg::ACC_W-1:0] div_offset,
  output logic mod_active,
  output logic ramp_rising,
  output logic second_start,
  output logic align_order_err
);
  import ssm_pkg::*;

  logic [31:0] cfg_ff;
  logic [31:0] nxt_cfg;
  logic cfg_load;
  logic [31:0] rdata_ff;
  logic signed [ACC_W-1:0] offset_ff;
  logic active_ff;
  logic rising_ff;
  logic start_ff;
  logic order_err_ff;
  logic wr_hit;
  logic en_rise;
  logic tick;
  logic signed [ACC_W-1:0] ramp_acc;
  ssm_ramp_state_type ramp_state;
  logic signed [ACC_W-1:0] lim;
  logic signed [ACC_W-1:0] dn;
  logic signed [ACC_W-1:0] up;

  assign wr_hit = reg_wr && (reg_addr == ADDR_SPREAD_CONFIG);
  assign cfg_load = nvm_load || wr_hit;
  // The startup load takes priority over a coincident serial write.
  assign nxt_cfg = (nvm_load ? nvm_data : reg_wdata) & CFG_WRITE_MASK;
  assign en_rise = cfg_load && nxt_cfg[EN_BIT] && !cfg_ff[EN_BIT];

  // Configuration register.
  always_ff @(posedge clock) begin
    if (srst) begin
      cfg_ff <= RESET_CONFIG;
    end else if (cfg_load) begin
      cfg_ff <= nxt_cfg;
    end
  end

  // Register read port; unmapped addresses read as zero.
  always_ff @(posedge clock) begin
    if (srst) begin
      rdata_ff <= '0;
    end else if (reg_rd) begin
      if (reg_addr == ADDR_SPREAD_CONFIG) begin
        rdata_ff <= cfg_ff;
      end else begin
        rdata_ff <= '0;
      end
    end
  end

  // With phase_align set, the second channel starts with the first channel's enable.
  always_ff @(posedge clock) begin
    if (srst) begin
      start_ff <= 1'b0;
    end else begin
      start_ff <= phase_align && en_rise;
    end
  end

  // Flags a serial enable that came before the second channel's enable.
  always_ff @(posedge clock) begin
    if (srst) begin
      order_err_ff <= 1'b0;
    end else if (phase_align && en_rise && !nvm_load && !second_en) begin
      order_err_ff <= 1'b1;
    end else if (cfg_load && !nxt_cfg[EN_BIT]) begin
      order_err_ff <= 1'b0;
    end
  end

  ssm_tick_div u_tick (
    .clock(clock),
    .srst(srst),
    .run(cfg_ff[EN_BIT]),
    .tick(tick)
  );

  ssm_ramp u_ramp (
    .clock(clock),
    .srst(srst),
    .run(cfg_ff[EN_BIT]),
    .tick(tick),
    .center(cfg_ff[MODE_BIT]),
    .ampl(cfg_ff[AMPL_MSB:AMPL_LSB]),
    .step(cfg_ff[STEP_MSB:STEP_LSB]),
    .acc(ramp_acc),
    .state(ramp_state)
  );

  // Offset and status outputs.
  always_ff @(posedge clock) begin
    if (srst) begin
      offset_ff <= '0;
      active_ff <= 1'b0;
      rising_ff <= 1'b0;
    end else begin
      offset_ff <= cfg_ff[EN_BIT] ? ramp_acc : '0;
      active_ff <= cfg_ff[EN_BIT];
      rising_ff <= (ramp_state == RAMP_RISE);
    end
  end

  assign reg_rdata = rdata_ff;
  assign div_offset = offset_ff;
  assign mod_active = active_ff;
  assign ramp_rising = rising_ff;
  assign second_start = start_ff;
  assign align_order_err = order_err_ff;

  // Helper values for checking the ramp.
  assign lim = ssm_limit(cfg_ff[AMPL_MSB:AMPL_LSB]);
  assign dn = ramp_acc - $signed({9'h000, cfg_ff[STEP_MSB:STEP_LSB]});
  assign up = ramp_acc + $signed({9'h000, cfg_ff[STEP_MSB:STEP_LSB]});

  chk_offset_off: assert property (
    @(posedge clock) disable iff (srst)
    !cfg_ff[EN_BIT] |=> (div_offset == '0))
    else $error("Offset nonzero while modulation disabled.");

  chk_offset_follow: assert property (
    @(posedge clock) disable iff (srst)
    cfg_ff[EN_BIT] |=> (div_offset == $past(ramp_acc)))
    else $error("Offset does not follow the ramp.");

  chk_second_start: assert property (
    @(posedge clock) disable iff (srst)
    $rose(cfg_ff[EN_BIT]) && $past(phase_align) |-> second_start)
    else $error("Second channel not started with enable.");

  chk_start_cause: assert property (
    @(posedge clock) disable iff (srst)
    second_start |-> $rose(cfg_ff[EN_BIT]) ##1 !second_start)
    else $error("Second channel start without enable rise.");

  chk_order_flag: assert property (
    @(posedge clock) disable iff (srst)
    $rose(align_order_err) |->
      $past(phase_align && !second_en && !nvm_load) &&
      $rose(cfg_ff[EN_BIT]))
    else $error("Order fault raised without a cause.");

  chk_nvm_order: assert property (
    @(posedge clock) disable iff (srst)
    nvm_load && !align_order_err |=> !align_order_err)
    else $error("Startup load raised an order fault.");

  chk_down_top: assert property (
    @(posedge clock) disable iff (srst)
    tick && cfg_ff[MODE_BIT] == MODE_DOWN && ramp_acc <= 0 &&
      !cfg_load |=> ramp_acc <= 0)
    else $error("Down spread ramp went above zero.");

  chk_lower_bound: assert property (
    @(posedge clock) disable iff (srst)
    tick && ramp_acc >= -lim && !cfg_load |=> ramp_acc >= -$past(lim))
    else $error("Ramp passed the lower limit.");

  chk_center_top: assert property (
    @(posedge clock) disable iff (srst)
    tick && cfg_ff[MODE_BIT] == MODE_CENTER && ramp_acc <= lim &&
      !cfg_load |=> ramp_acc <= $past(lim))
    else $error("Center spread ramp passed the upper limit.");

  chk_tick_period: assert property (
    @(posedge clock) disable iff (srst || !cfg_ff[EN_BIT] || cfg_load)
    tick |=> (!tick) [*7] ##1 tick)
    else $error("Ramp tick period is not eight clocks.");

  chk_reset_cfg: assert property (
    @(posedge clock) disable iff (srst)
    $fell(srst) |-> (cfg_ff == RESET_CONFIG))
    else $error("Configuration reset value wrong.");

  chk_fall_turn: assert property (
    @(posedge clock) disable iff (srst)
    tick && cfg_ff[EN_BIT] && !cfg_load && ramp_state == RAMP_FALL &&
      dn <= -lim |=> ramp_state == RAMP_RISE && ramp_acc == -$past(lim))
    else $error("Ramp did not turn at the lower limit.");

  chk_rise_turn: assert property (
    @(posedge clock) disable iff (srst)
    tick && cfg_ff[EN_BIT] && !cfg_load && ramp_state == RAMP_RISE &&
      cfg_ff[MODE_BIT] == MODE_DOWN && up >= 0 |=>
      ramp_state == RAMP_FALL && ramp_acc == 0)
    else $error("Ramp did not turn at the upper limit.");

  chk_idle_zero: assert property (
    @(posedge clock) disable iff (srst)
    !cfg_ff[EN_BIT] |=> ramp_acc == 0 && ramp_state == RAMP_IDLE)
    else $error("Ramp not held at zero while disabled.");

  chk_start_down: assert property (
    @(posedge clock) disable iff (srst)
    $rose(cfg_ff[EN_BIT]) && !cfg_load |=> ramp_state == RAMP_FALL)
    else $error("Ramp did not start downward.");
endmodule : ssm_modulator
`default_nettype wire

// >>> src/ssm_pkg.sv
// Constants and types shared by the spread-spectrum modulator files.
// Assumes a single 200 MHz system clock and a synchronous reset.
package ssm_pkg;
  // Register map.
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_SPREAD_CONFIG = 8'h00;
  // Field positions of spread_config.
  localparam int EN_BIT = 31;
  localparam int MODE_BIT = 30;
  localparam int AMPL_MSB = 23;
  localparam int AMPL_LSB = 16;
  localparam int STEP_MSB = 15;
  localparam int STEP_LSB = 0;
  localparam logic [31:0] CFG_WRITE_MASK = 32'hc0ff_ffff;
  // Reset values.
  localparam logic RESET_EN = 1'h0;
  localparam logic RESET_MODE = 1'h0;
  localparam logic [7:0] RESET_AMPL = 8'h51;
  localparam logic [15:0] RESET_STEP = 16'h2b8c;
  localparam logic [31:0] RESET_CONFIG = {RESET_EN, RESET_MODE, 6'h00,
    RESET_AMPL, RESET_STEP};
  // Spread direction codes.
  localparam logic MODE_DOWN = 1'h0;
  localparam logic MODE_CENTER = 1'h1;
  // Ramp update tick: system clock divided by eight.
  localparam int TICK_DIV = 8;
  localparam int TICK_CNT_W = 3;
  localparam logic [2:0] TICK_LAST = 3'(TICK_DIV - 1);
  // Accumulator scaling: amplitude LSB moved into step units.
  localparam int AMPL_SHIFT = 15;
  localparam int ACC_W = 25;

  typedef enum logic [1:0] {
    RAMP_IDLE = 2'b00,
    RAMP_FALL = 2'b01,
    RAMP_RISE = 2'b10
  } ssm_ramp_state_type;

  // Converts an amplitude code to an accumulator limit.
  function automatic logic signed [ACC_W-1:0] ssm_limit(
    input logic [7:0] ampl);
    ssm_limit = $signed({2'h0, ampl, 15'h0000});
  endfunction : ssm_limit
endpackage : ssm_pkg

// >>> src/ssm_tick_div.sv
// Divide-by-eight tick generator for ramp updates.
// Assumes run comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ssm_tick_div (
  input wire logic clock,
  input wire logic srst,
  input wire logic run,
  output logic tick
);
  import ssm_pkg::*;

  logic [TICK_CNT_W-1:0] cnt_ff;
  logic tick_ff;

  // Counter restarts whenever the ramp stops, so ticks align to enable.
  always_ff @(posedge clock) begin
    if (srst || !run) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= cnt_ff + 3'h1;
      tick_ff <= (cnt_ff == TICK_LAST);
    end
  end

  assign tick = tick_ff;
endmodule : ssm_tick_div
`default_nettype wire

// >>> src/ssm_ramp.sv
// Triangular ramp accumulator between programmable limits.
// Assumes tick is a one-cycle enable from the tick divider.
`timescale 1ns/1ps
`default_nettype none
module ssm_ramp (
  input wire logic clock,
  input wire logic srst,
  input wire logic run,
  input wire logic tick,
  input wire logic center,
  input wire logic [7:0] ampl,
  input wire logic [15:0] step,
  output logic signed [ssm_pkg::ACC_W-1:0] acc,
  output ssm_pkg::ssm_ramp_state_type state
);
  import ssm_pkg::*;

  logic signed [ACC_W-1:0] acc_ff;
  ssm_ramp_state_type state_ff;
  logic signed [ACC_W-1:0] lim;
  logic signed [ACC_W-1:0] top;
  logic signed [ACC_W-1:0] stp;
  logic signed [ACC_W-1:0] dn;
  logic signed [ACC_W-1:0] up;

  assign lim = ssm_limit(ampl);
  assign top = (center == MODE_CENTER) ? lim : '0;
  assign stp = $signed({9'h000, step});
  assign dn = acc_ff - stp;
  assign up = acc_ff + stp;

  always_ff @(posedge clock) begin
    if (srst || !run) begin
      acc_ff <= '0;
      state_ff <= RAMP_IDLE;
    end else begin
      unique case (state_ff)
        RAMP_IDLE: begin
          state_ff <= RAMP_FALL;
        end
        RAMP_FALL: begin
          if (tick) begin
            if (dn <= -lim) begin
              acc_ff <= -lim;
              state_ff <= RAMP_RISE;
            end else begin
              acc_ff <= dn;
            end
          end
        end
        RAMP_RISE: begin
          if (tick) begin
            if (up >= top) begin
              acc_ff <= top;
              state_ff <= RAMP_FALL;
            end else begin
              acc_ff <= up;
            end
          end
        end
        default: begin
          state_ff <= RAMP_IDLE;
        end
      endcase
    end
  end

  assign acc = acc_ff;
  assign state = state_ff;
endmodule : ssm_ramp
`default_nettype wire

// >>> bench/tb.sv
// Testbench for the spread-spectrum modulator: register access, ramp
// shape, tick rate and second-channel start sequencing.
// Assumes the package and the modulator top are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ssm_pkg::*;
  logic clock;
  logic srst;
  logic reg_wr;
  logic reg_rd;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata;
  logic nvm_load;
  logic [31:0] nvm_data;
  logic phase_align;
  logic second_en;
  logic [31:0] reg_rdata;
  logic signed [ACC_W-1:0] div_offset;
  logic mod_active;
  logic ramp_rising;
  logic second_start;
  logic align_order_err;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  int nchg;
  int npulse;
  logic signed [ACC_W-1:0] lo;
  logic signed [ACC_W-1:0] hi;
  logic signed [ACC_W-1:0] first_off;
  logic saw_rise;
  logic [31:0] rd;
  logic md [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  logic [7:0] am [4] = '{8'h01, 8'h01, 8'h02, 8'h03};
  logic [15:0] st [4] = '{16'h5000, 16'h5000, 16'h4000, 16'h6000};

  ssm_modulator i_dut (
    .clock(clock), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .nvm_load(nvm_load),
    .nvm_data(nvm_data), .phase_align(phase_align),
    .second_en(second_en), .reg_rdata(reg_rdata),
    .div_offset(div_offset), .mod_active(mod_active),
    .ramp_rising(ramp_rising), .second_start(second_start),
    .align_order_err(align_order_err)
  );

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic test_done();
    $display("Counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      test_done();
    end
  end

  task automatic chk_word(input string what, input logic [31:0] e,
                          input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : chk_word

  task automatic chk_off(input string what, input logic signed [ACC_W-1:0] e,
                         input logic signed [ACC_W-1:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %0d seen %0d", what, e, g);
    end
  endtask : chk_off

  task automatic chk_bit(input string what, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %b seen %b", what, e, g);
    end
  endtask : chk_bit

  task automatic write_cfg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : write_cfg

  task automatic load_cfg(input logic [31:0] d);
    @(posedge clock);
    nvm_load <= 1'b1;
    nvm_data <= d;
    @(posedge clock);
    nvm_load <= 1'b0;
  endtask : load_cfg

  task automatic read_cfg(input logic [7:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    #1 rd = reg_rdata;
  endtask : read_cfg

  // Samples the outputs for n cycles and gathers ramp statistics.
  task automatic watch(input int n);
    logic signed [ACC_W-1:0] prev;
    // Steps off the edge so a pulse launched by the last request counts.
    #1;
    prev = div_offset;
    lo = div_offset;
    hi = div_offset;
    nchg = 0;
    npulse = (second_start === 1'b1) ? 1 : 0;
    saw_rise = 1'b0;
    first_off = '0;
    repeat (n) begin
      @(posedge clock);
      #1;
      if (div_offset < lo) lo = div_offset;
      if (div_offset > hi) hi = div_offset;
      if (div_offset !== prev) nchg++;
      if (first_off == 0) first_off = div_offset;
      if (ramp_rising === 1'b1) saw_rise = 1'b1;
      if (second_start === 1'b1) npulse++;
      prev = div_offset;
    end
  endtask : watch

  initial begin
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    nvm_load = 1'b0;
    nvm_data = '0;
    phase_align = 1'b0;
    second_en = 1'b0;
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    read_cfg(8'h00);
    chk_word("reset config", 32'h0051_2b8c, rd);
    chk_bit("idle active", 1'b0, mod_active);
    chk_off("idle offset", '0, div_offset);
    write_cfg(8'h04, 32'h4012_3456);
    read_cfg(8'h04);
    chk_word("unmapped read", 32'h0000_0000, rd);
    read_cfg(8'h00);
    chk_word("config kept", 32'h0051_2b8c, rd);
    write_cfg(8'h00, 32'h7fff_ffff);
    read_cfg(8'h00);
    chk_word("reserved bits", 32'h40ff_ffff, rd);
    watch(40);
    chk_off("disabled high", '0, hi);
    chk_off("disabled low", '0, lo);
    for (int i = 0; i < 4; i++) begin
      write_cfg(8'h00, {1'b1, md[i], 6'h00, am[i], st[i]});
      watch(24);
      chk_bit("starts down", 1'b1, first_off[ACC_W-1]);
      chk_word("no start pulse", 32'h0, npulse);
      watch(200);
      chk_off("ramp low", -(int'(am[i]) * 32768), lo);
      chk_off("ramp high", md[i] ? int'(am[i]) * 32768 : 0, hi);
      chk_word("tick count", 32'd25, nchg);
      chk_bit("ramp turns", 1'b1, saw_rise);
      chk_bit("active on", 1'b1, mod_active);
      write_cfg(8'h00, {2'b00, 6'h00, am[i], st[i]});
      watch(4);
      chk_off("offset off", '0, div_offset);
      chk_bit("active off", 1'b0, mod_active);
    end
    @(posedge clock);
    phase_align <= 1'b1;
    write_cfg(8'h00, 32'h8051_2b8c);
    watch(4);
    chk_word("aligned start", 32'h1, npulse);
    chk_bit("order error", 1'b1, align_order_err);
    write_cfg(8'h00, 32'h0051_2b8c);
    watch(4);
    chk_bit("order cleared", 1'b0, align_order_err);
    @(posedge clock);
    second_en <= 1'b1;
    write_cfg(8'h00, 32'hc051_5718);
    watch(4);
    chk_word("ordered start", 32'h1, npulse);
    chk_bit("no order error", 1'b0, align_order_err);
    write_cfg(8'h00, 32'h0051_2b8c);
    @(posedge clock);
    second_en <= 1'b0;
    load_cfg(32'hbf12_3456);
    watch(4);
    chk_word("load start", 32'h1, npulse);
    chk_bit("load no error", 1'b0, align_order_err);
    read_cfg(8'h00);
    chk_word("loaded config", 32'h8012_3456, rd);
    test_done();
  end
endmodule : tb
`default_nettype wire
